// ---- rtl/voice_ctrl.sv ----
// Purpose: cycle control of a single-chip voice record/playback device
// Assumes: pins are asynchronous to core_clk and pass two flip-flops
// Notes: analog path, operational-mode decoding and cascading are outside
// Functional notes
// - External clock is divided by two before any internal use.
// - Direction latched at chip select falling edge, held for the cycle.
// - Latched high starts playback, latched low starts record.
// - Record starts at given address, runs until power-down or select high.
// - Record stops itself when the pointer passes the array end.
// - Record ended by power-down or select writes an end marker there.
// - Playback starts at given address, runs to the next end marker.
// - Playback passes a marker while select is held low.
// - Address latched with direction at select fall; start only while low.
// - End-of-message output pulses low a fixed time at message end.
// - Power-down means standby and resets the pointer after overflow.
// - Both top address bits high means mode bits, not an address.
`include "voice_ctrl_params.svh"
module voice_ctrl
   import voice_ctrl_pkg::*;
#(
   parameter int ADDR_W = `ADDR_W,
   parameter logic [15:0] SAMPLES_PER_ROW = `SAMPLES_PER_ROW,
   parameter int END_PULSE_CYC = `END_PULSE_CYC
) (
   input wire logic core_clk, // system clock
   input wire logic srst, // synchronous reset
   input wire logic chip_enable_n, // chip select pin
   input wire logic play_record, // 1 play, 0 record
   input wire logic power_down, // standby pin
   input wire logic [ADDR_W-1:0] addr_in, // start address or mode bits
   input wire logic external_sample_clock, // external clock pin
   input wire logic ext_clk_select, // 1 when external clock is used
   input wire logic internal_sample_tick, // internal sampling clock tick
   input wire logic marker_found, // stored marker at current row
   output logic message_end_marker_n, // end-of-message pulse
   output logic overflow_out_n, // overflow flag
   output logic [ADDR_W-1:0] row_addr, // current pointer
   output logic recording, // record cycle active
   output logic playing, // playback cycle active
   output logic marker_write, // write marker at row_addr
   output logic mode_request // address decoded as mode bits
);
   // ==========================================
   // Synchronisers
   logic [1:0] ce_s, pr_s, pwr_s, xc_s;
   logic [2*ADDR_W-1:0] ad_s;
   logic ce_prev, xc_prev, xdiv;
   logic ce_fall, ext_tick, samp_tick, row_tick;
   logic [15:0] samp_cnt, next_samp_cnt;
   logic ce_n, pwr_dn;
   logic [ADDR_W-1:0] addr_q;
   logic next_xdiv;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ce_s <= 2'h3;
         pr_s <= 2'h0;
         pwr_s <= 2'h3;
         xc_s <= 2'h0;
         ad_s <= '0;
         ce_prev <= 1'b1;
         xc_prev <= 1'b0;
      end else begin
         ce_s <= {ce_s[0], chip_enable_n};
         pr_s <= {pr_s[0], play_record};
         pwr_s <= {pwr_s[0], power_down};
         xc_s <= {xc_s[0], external_sample_clock};
         ad_s <= {ad_s[ADDR_W-1:0], addr_in};
         ce_prev <= ce_s[1];
         xc_prev <= xc_s[1];
      end
   end
   assign ce_n = ce_s[1];
   assign pwr_dn = pwr_s[1];
   assign addr_q = ad_s[2*ADDR_W-1:ADDR_W];
   assign ce_fall = ce_prev & ~ce_n;

   // ==========================================
   // Sample rate: rising edges only, so duty cycle is irrelevant
   always_comb begin
      next_xdiv = xdiv;
      if (xc_s[1] & ~xc_prev) begin
         next_xdiv = ~xdiv;
      end
   end
   assign ext_tick = xc_s[1] & ~xc_prev & xdiv;
   assign samp_tick = ext_clk_select ? ext_tick : internal_sample_tick;
   assign row_tick = samp_tick && (samp_cnt == SAMPLES_PER_ROW - 16'h0001);
   always_comb begin
      next_samp_cnt = samp_cnt;
      if (!(recording || playing)) begin
         next_samp_cnt = 16'h0000;
      end else if (row_tick) begin
         next_samp_cnt = 16'h0000;
      end else if (samp_tick) begin
         next_samp_cnt = samp_cnt + 16'h0001;
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         xdiv <= 1'b0;
         samp_cnt <= 16'h0000;
      end else begin
         xdiv <= next_xdiv;
         samp_cnt <= next_samp_cnt;
      end
   end

   // ==========================================
   // Cycle control
   cycle_state_t state, next_state;
   start_req_t req, next_req;
   logic [ADDR_W-1:0] next_row_addr;
   logic next_overflow_n, next_mode_request;
   logic [15:0] end_cnt, next_end_cnt;
   logic at_end;
   assign at_end = (row_addr == ADDR_W'(`ADDR_LAST));

   always_comb begin
      next_state = state;
      next_req = req;
      next_row_addr = row_addr;
      next_overflow_n = overflow_out_n;
      next_mode_request = mode_request;
      next_end_cnt = (end_cnt != 16'h0000) ? end_cnt - 16'h0001 : 16'h0000;
      case (state)
         ST_IDLE: begin
            if (ce_fall && !pwr_dn) begin
               next_req.direction = pr_s[1];
               next_req.start_addr = addr_q;
               next_req.mode_sel = addr_q[`MODE_BIT_HI] & addr_q[`MODE_BIT_LO];
               next_mode_request = next_req.mode_sel;
               next_row_addr = next_req.mode_sel ? '0 : addr_q;
               next_state = pr_s[1] ? ST_PLAY : ST_REC;
            end
         end
         ST_REC: begin
            if (pwr_dn || ce_n) begin
               next_state = ST_MARK;
            end else if (row_tick) begin
               if (at_end) begin
                  next_overflow_n = 1'b0;
                  next_state = ST_FULL;
               end else begin
                  next_row_addr = row_addr + 1'b1;
               end
            end
         end
         ST_MARK: begin
            next_state = ST_IDLE;
         end
         ST_PLAY: begin
            if (pwr_dn) begin
               next_state = ST_IDLE;
            end else if (row_tick) begin
               if (marker_found) begin
                  next_end_cnt = 16'(END_PULSE_CYC);
               end
               if (at_end) begin
                  next_overflow_n = 1'b0;
                  next_state = ST_FULL;
               end else if (marker_found && ce_n) begin
                  next_state = ST_IDLE;
               end else begin
                  next_row_addr = row_addr + 1'b1;
               end
            end
         end
         ST_FULL: begin
            if (pwr_dn) begin
               next_row_addr = '0;
               next_overflow_n = 1'b1;
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= ST_IDLE;
         req <= '0;
         row_addr <= '0;
         overflow_out_n <= 1'b1;
         mode_request <= 1'b0;
         end_cnt <= 16'h0000;
      end else begin
         state <= next_state;
         req <= next_req;
         row_addr <= next_row_addr;
         overflow_out_n <= next_overflow_n;
         mode_request <= next_mode_request;
         end_cnt <= next_end_cnt;
      end
   end
   assign recording = (state == ST_REC);
   assign playing = (state == ST_PLAY);
   assign marker_write = (state == ST_MARK);
   assign message_end_marker_n = (end_cnt == 16'h0000);

   // ==========================================
   // Checks
   chk_start_dir: assert property (@(posedge core_clk) disable iff (srst)
      (state == ST_IDLE && ce_fall && !pwr_dn) |=> (playing == $past(pr_s[1]))
      && (recording == !$past(pr_s[1])))
      else $error("cycle kind does not follow latched direction");
   chk_dir_held: assert property (@(posedge core_clk) disable iff (srst)
      (state != ST_IDLE && $past(state) != ST_IDLE) |-> $stable(req.direction))
      else $error("direction changed mid cycle");
   chk_rec_stop: assert property (@(posedge core_clk) disable iff (srst)
      (recording && (pwr_dn || ce_n)) |=> marker_write ##1 state == ST_IDLE)
      else $error("record did not end with marker");
   chk_mark_addr: assert property (@(posedge core_clk) disable iff (srst)
      marker_write |-> $stable(row_addr))
      else $error("marker written at moved address");
   chk_overflow_stop: assert property (@(posedge core_clk) disable iff (srst)
      (recording && !pwr_dn && !ce_n && row_tick && at_end)
      |=> !overflow_out_n && !recording)
      else $error("overflow not taken");
   chk_start_addr: assert property (@(posedge core_clk) disable iff (srst)
      (state == ST_IDLE && ce_fall && !pwr_dn
      && !(addr_q[`MODE_BIT_HI] && addr_q[`MODE_BIT_LO]))
      |=> row_addr == $past(addr_q))
      else $error("start address not loaded");
   chk_mode_dec: assert property (@(posedge core_clk) disable iff (srst)
      (state == ST_IDLE && ce_fall && !pwr_dn
      && addr_q[`MODE_BIT_HI] && addr_q[`MODE_BIT_LO])
      |=> mode_request && row_addr == '0)
      else $error("mode bits taken as address");
   chk_play_pass: assert property (@(posedge core_clk) disable iff (srst)
      (playing && !pwr_dn && row_tick && marker_found && !ce_n && !at_end) |=> playing)
      else $error("playback stopped with select low");
   chk_end_pulse: assert property (@(posedge core_clk) disable iff (srst)
      (playing && !pwr_dn && row_tick && marker_found) |=> !message_end_marker_n [*8])
      else $error("end pulse too short");
   chk_overflow_clr: assert property (@(posedge core_clk) disable iff (srst)
      (state == ST_FULL && pwr_dn) |=> row_addr == '0 && overflow_out_n)
      else $error("pointer not reset after overflow");
   chk_standby_hold: assert property (@(posedge core_clk) disable iff (srst)
      (state == ST_IDLE && pwr_dn) |=> state == ST_IDLE)
      else $error("cycle started in standby");
   chk_row_step: assert property (@(posedge core_clk) disable iff (srst)
      (recording && !pwr_dn && !ce_n && row_tick && !at_end)
      |=> row_addr == $past(row_addr) + 1'b1)
      else $error("pointer did not advance");
endmodule : voice_ctrl

// ---- rtl/voice_ctrl_params.svh ----
// Purpose: constants for the voice record/playback control block
// Assumes: core_clk at 50 MHz
// Notes: counts derived from times in their own units
`ifndef VOICE_CTRL_PARAMS_SVH
`define VOICE_CTRL_PARAMS_SVH
// ==========================================
// Address layout
`define ADDR_W 10
`define ADDR_LAST 10'h257
`define MODE_BIT_LO 8
`define MODE_BIT_HI 9
// ==========================================
// Timing
`define CLK_PERIOD_NS 20
`define END_PULSE_US 12
`define END_PULSE_CYC ((`END_PULSE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAMPLES_PER_ROW 16'h0100
`endif

// ---- rtl/voice_ctrl_pkg.sv ----
// Purpose: types for the voice record/playback control block
// Assumes: voice_ctrl_params.svh for numbers
// Notes: none
package voice_ctrl_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_REC = 3'b001,
      ST_PLAY = 3'b010,
      ST_MARK = 3'b011,
      ST_FULL = 3'b100
   } cycle_state_t;

   typedef struct packed {
      logic direction;
      logic mode_sel;
      logic [9:0] start_addr;
   } start_req_t;
endpackage : voice_ctrl_pkg

// ---- tb/voice_host_model.sv ----
// Purpose: far-side model: sample clocks and marker storage
// Assumes: one marker bit per row, kept across cycles
// Notes: external clock has a lopsided duty on purpose
module voice_host_model (
   input wire logic core_clk, // system clock
   input wire logic ext_sel, // external clock in use
   input wire logic [9:0] row_addr, // device pointer
   input wire logic marker_write, // marker store strobe
   output logic sample_tick, // internal sample tick
   output logic ext_clk, // external clock pin
   output logic marker_found // marker at pointer
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Clocks and marker array
   logic marks [0:1023];
   logic ext_run;
   initial begin
      ext_run = 1'b0;
      sample_tick = 1'b0;
      foreach (marks[i]) marks[i] = 1'b0;
      forever begin
         #13 ext_run = 1'b1;
         #47 ext_run = 1'b0;
      end
   end
   assign ext_clk = ext_sel ? ext_run : 1'b0;
   always @(posedge core_clk) begin
      sample_tick <= ~sample_tick;
      if (marker_write) begin
         marks[row_addr] <= 1'b1;
      end
   end
   assign marker_found = marks[row_addr];
endmodule : voice_host_model

// ---- tb/voice_record_playback_control_bench.sv ----
// Purpose: self-checking bench of the cycle control block
// Assumes: 4 ticks per row, 8-cycle end pulse
// Notes: pins change on the falling edge
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module voice_record_playback_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import voice_ctrl_pkg::*;
   logic core_clk = 0, srst = 1, ce_n = 1, dir = 0, pwr_dn = 0, ext_sel = 0;
   logic [9:0] addr = 0, row_addr, m;
   logic tick, ext_pin, found, msg_end_n, overflow_n, rec, play, mwr, mode;
   int n_fail = 0, tests_run = 0;
   voice_ctrl #(.SAMPLES_PER_ROW(16'h0004), .END_PULSE_CYC(8)) u_voice_ctrl (
      .core_clk(core_clk), .srst(srst), .chip_enable_n(ce_n), .play_record(dir),
      .power_down(pwr_dn), .addr_in(addr), .external_sample_clock(ext_pin),
      .ext_clk_select(ext_sel), .internal_sample_tick(tick), .marker_found(found),
      .message_end_marker_n(msg_end_n), .overflow_out_n(overflow_n), .row_addr(row_addr),
      .recording(rec), .playing(play), .marker_write(mwr), .mode_request(mode));
   voice_host_model u_voice_host_model (.core_clk(core_clk), .ext_sel(ext_sel),
      .row_addr(row_addr), .marker_write(mwr), .sample_tick(tick), .ext_clk(ext_pin),
      .marker_found(found));
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   // ==========================================
   // Helpers
   task automatic end_of_test();
      if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   function automatic logic sig(input int k);
      case (k)
         0: return rec;
         1: return play;
         2: return mwr;
         default: return overflow_n;
      endcase
   endfunction : sig
   task automatic wait_on(input int k, input logic v);
      int n;
      n = 0;
      while (sig(k) !== v && n < 2000) begin
         @(negedge core_clk);
         n++;
      end
      `CHK("wait", v, sig(k))
   endtask : wait_on
   task automatic start(input logic d, input logic [9:0] a);
      @(negedge core_clk);
      dir = d;
      addr = a;
      ce_n = 0;
      wait_on(d ? 1 : 0, 1'b1);
   endtask : start
   task automatic idle(input int c);
      repeat (c) @(negedge core_clk);
   endtask : idle
   // ==========================================
   // Scenarios
   task automatic t_record();
      start(1'b0, 10'h010);
      `CHK("start row", 10'h010, row_addr)
      `CHK("no play", 1'b0, play)
      dir = 1'b1;
      idle(40);
      `CHK("held dir", 1'b1, rec)
      `CHK("advance", 1'b1, row_addr > 10'h012)
      ce_n = 1'b1;
      wait_on(2, 1'b1);
      m = row_addr;
      idle(1);
      `CHK("rec end", 1'b0, rec)
   endtask : t_record
   task automatic t_play();
      start(1'b1, m - 10'h002);
      ce_n = 1'b1;
      wait_on(1, 1'b0);
      `CHK("stop row", m, row_addr)
      `CHK("end low", 1'b0, msg_end_n)
      idle(10);
      `CHK("end back", 1'b1, msg_end_n)
      start(1'b1, m - 10'h001);
      idle(40);
      `CHK("pass marker", 1'b1, play)
      pwr_dn = 1'b1;
      wait_on(1, 1'b0);
      ce_n = 1'b1;
      pwr_dn = 1'b0;
      idle(6);
   endtask : t_play
   task automatic t_overflow();
      start(1'b0, 10'h254);
      wait_on(3, 1'b0);
      idle(1);
      `CHK("overflow stop", 1'b0, rec)
      ce_n = 1'b1;
      pwr_dn = 1'b1;
      idle(6);
      `CHK("overflow clear", 1'b1, overflow_n)
      `CHK("ptr reset", 10'h000, row_addr)
      // A select fall in standby must not start anything
      ce_n = 1'b0;
      idle(6);
      `CHK("standby", 1'b0, rec)
      ce_n = 1'b1;
      pwr_dn = 1'b0;
      idle(6);
   endtask : t_overflow
   task automatic t_ext_mode();
      ext_sel = 1'b1;
      start(1'b0, 10'h100);
      idle(120);
      // Row every 24 cycles when halved; 12 if the halving is missing
      `CHK("ext rate", 1'b1, row_addr >= 10'h103 && row_addr <= 10'h105)
      ce_n = 1'b1;
      ext_sel = 1'b0;
      idle(8);
      start(1'b0, 10'h3c0);
      `CHK("mode", 1'b1, mode)
      ce_n = 1'b1;
      idle(8);
   endtask : t_ext_mode
   initial begin
      idle(10);
      srst = 1'b0;
      idle(2);
      t_record();
      t_play();
      t_overflow();
      t_ext_mode();
      end_of_test();
   end
   initial begin
      #400000;
      n_fail++;
      end_of_test();
   end
endmodule : voice_record_playback_control_bench
